// ==== src/msc_pkg.sv ====
package msc_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int SAMPLE_W = 12;
   localparam int PHASE_W = 16;
   localparam int AMP_W = 16;
   localparam int FSK_ACC_W = 48;
   localparam int CFG_N = 18;
   // timing: clock period and sweep step length
   localparam int CLK_PERIOD_NS = 20;
   localparam int STEP_TIME_NS = 320;
   localparam int STEP_CYCLES = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // am gain is q10, full gain span q11
   localparam logic [31:0] AM_ONE = 32'h0000_0400;
   localparam int AM_SHIFT = 11;
   localparam int LOG_SHIFT = 24;
   // byte offsets
   localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_CARRIER = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_HOP = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_FM_DEV = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_PM_DEV = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_AM_DEPTH = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_AMPLITUDE = 8'h18;
   localparam logic [ADDR_W-1:0] OFF_PW_NOM = 8'h1C;
   localparam logic [ADDR_W-1:0] OFF_PW_DEV = 8'h20;
   localparam logic [ADDR_W-1:0] OFF_MOD_INC = 8'h24;
   localparam logic [ADDR_W-1:0] OFF_FSK_LO = 8'h28;
   localparam logic [ADDR_W-1:0] OFF_FSK_HI = 8'h2C;
   localparam logic [ADDR_W-1:0] OFF_SW_START = 8'h30;
   localparam logic [ADDR_W-1:0] OFF_SW_STOP = 8'h34;
   localparam logic [ADDR_W-1:0] OFF_SW_TIME = 8'h38;
   localparam logic [ADDR_W-1:0] OFF_SW_LIN = 8'h3C;
   localparam logic [ADDR_W-1:0] OFF_SW_LOG = 8'h40;
   localparam logic [ADDR_W-1:0] OFF_MARKER = 8'h44;
   localparam logic [ADDR_W-1:0] OFF_CMD = 8'h48;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h4C;
   localparam logic [ADDR_W-1:0] OFF_PINC = 8'h50;
   // command bits
   localparam int CMD_TRIG = 0;
   localparam int CMD_CLR_REJ = 1;
   localparam logic [DATA_W-1:0] REG_RST = 32'h0000_0000;

   typedef enum logic [2:0] {MOD_NONE, MOD_AM, MOD_FM, MOD_PM, MOD_FSK, MOD_PWM} mod_mode_type;
   typedef enum logic {SW_IDLE, SW_RUN} sweep_state_type;

   typedef struct packed {
      logic [20:0] spare;
      logic trig_out_en;
      logic marker_en;
      logic sweep_ext;
      logic sweep_log;
      logic sweep_en;
      logic fsk_ext;
      logic pulse_wave;
      logic ext_src;
      logic [2:0] mode;
   } ctrl_type;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } reg_req_type;
endpackage

// ==== src/modulation_sweep_control.sv ====
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
module modulation_sweep_control #(
   parameter int SW = msc_pkg::SAMPLE_W
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // register port
   input wire msc_pkg::reg_req_type req,
   output logic [msc_pkg::DATA_W-1:0] rdata,
   // modulation adc
   input wire logic signed [SW-1:0] adc_sample,
   input wire logic adc_valid,
   // trigger pin and key
   input wire logic trig_in,
   output logic trig_out,
   output logic trig_drive_n,
   input wire logic key_trig,
   // synthesizer controls
   output logic [31:0] phase_increment_register,
   output logic [msc_pkg::PHASE_W-1:0] phase_out,
   output logic [msc_pkg::AMP_W-1:0] amp_out,
   output logic [31:0] width_out,
   output logic sync_out
);
   // product of a signed sample and a deviation, full-scale sample gives the deviation
   function automatic logic signed [31:0] scale(input logic signed [SW-1:0] s,
                                                input logic [31:0] k);
      logic signed [SW+32:0] p;
      p = $signed({1'b0, k}) * s;
      return p[SW+30:SW-1];
   endfunction

   logic [31:0] cfg_r [0:msc_pkg::CFG_N-1];
   logic [31:0] rdata_r;
   logic reject_r;
   logic trig_meta_r, trig_sync_r, trig_prev_r;
   logic signed [SW-1:0] ext_r;
   logic [31:0] mod_acc_r;
   logic [msc_pkg::FSK_ACC_W-1:0] fsk_acc_r;
   logic [31:0] phase_acc_r;
   logic [31:0] pinc_r;
   logic [msc_pkg::PHASE_W-1:0] phase_r;
   logic [msc_pkg::AMP_W-1:0] amp_r;
   logic [31:0] width_r;
   msc_pkg::sweep_state_type state_r;
   logic [31:0] freq_r, step_cnt_r, step_tmr_r;
   logic sync_r, trig_out_r, trig_drive_n_r;
   logic hop_sel;

   // field views of the register array
   msc_pkg::ctrl_type ctrl;
   wire [31:0] carrier = cfg_r[msc_pkg::OFF_CARRIER[6:2]];
   wire [31:0] hop = cfg_r[msc_pkg::OFF_HOP[6:2]];
   wire [31:0] sw_start = cfg_r[msc_pkg::OFF_SW_START[6:2]];
   wire [31:0] sw_stop = cfg_r[msc_pkg::OFF_SW_STOP[6:2]];
   wire [31:0] marker = cfg_r[msc_pkg::OFF_MARKER[6:2]];
   assign ctrl = msc_pkg::ctrl_type'(cfg_r[msc_pkg::OFF_CTRL[6:2]]);

   // bus decode
   wire in_cfg = req.addr < msc_pkg::OFF_CMD;
   wire [4:0] cfg_idx = req.addr[6:2];
   wire wr_cfg = req.wr && in_cfg && (req.addr[1:0] == 2'b00);
   wire wr_cmd = req.wr && (req.addr == msc_pkg::OFF_CMD);
   wire wr_marker = wr_cfg && (req.addr == msc_pkg::OFF_MARKER);
   wire [31:0] lo_bound = (sw_start < sw_stop) ? sw_start : sw_stop;
   wire [31:0] hi_bound = (sw_start < sw_stop) ? sw_stop : sw_start;
   wire marker_ok = (req.wdata >= lo_bound) && (req.wdata <= hi_bound);
   wire soft_trig = wr_cmd && req.wdata[msc_pkg::CMD_TRIG];

   // register writes; an out-of-range marker is dropped and flagged
   always_ff @(posedge clock) begin
      if (rst) begin
         for (int i = 0; i < msc_pkg::CFG_N; i++) begin
            cfg_r[i] <= msc_pkg::REG_RST;
         end
         reject_r <= 1'b0;
      end else begin
         if (wr_cfg && !(wr_marker && !marker_ok)) begin
            cfg_r[cfg_idx] <= req.wdata;
         end
         // a fresh rejection wins over a clear in the same cycle
         if (wr_marker && !marker_ok) begin
            reject_r <= 1'b1;
         end else if (wr_cmd && req.wdata[msc_pkg::CMD_CLR_REJ]) begin
            reject_r <= 1'b0;
         end
      end
   end

   // read mux, data valid only in the cycle after the strobe
   wire [31:0] status = {28'h000_0000, hop_sel, reject_r, sync_r, state_r == msc_pkg::SW_RUN};
   logic [31:0] rd_val;
   always_comb begin
      if (in_cfg) begin
         rd_val = cfg_r[cfg_idx];
      end else if (req.addr == msc_pkg::OFF_STATUS) begin
         rd_val = status;
      end else if (req.addr == msc_pkg::OFF_PINC) begin
         rd_val = pinc_r;
      end else begin
         rd_val = 32'h0000_0000;
      end
   end
   always_ff @(posedge clock) begin
      if (rst) rdata_r <= 32'h0000_0000;
      else rdata_r <= req.rd ? rd_val : 32'h0000_0000;
   end

   // trigger pin: two-flop synchroniser, edge taken from the second stage
   always_ff @(posedge clock) begin
      if (rst) begin
         trig_meta_r <= 1'b0;
         trig_sync_r <= 1'b0;
         trig_prev_r <= 1'b0;
      end else begin
         trig_meta_r <= trig_in;
         trig_sync_r <= trig_meta_r;
         trig_prev_r <= trig_sync_r;
      end
   end
   // pin is ignored as input while we drive it
   wire trig_rise = trig_sync_r && !trig_prev_r && !ctrl.trig_out_en;
   wire trig_lvl = trig_sync_r && !ctrl.trig_out_en;

   // modulating sample: secondary dds triangle or latest adc word
   wire [SW-1:0] tri_u = mod_acc_r[30 -: SW] ^ {SW{mod_acc_r[31]}};
   wire signed [SW-1:0] int_sample = {~tri_u[SW-1], tri_u[SW-2:0]};
   wire signed [SW-1:0] sample = ctrl.ext_src ? ext_r : int_sample;
   always_ff @(posedge clock) begin
      if (rst) begin
         mod_acc_r <= 32'h0000_0000;
         ext_r <= '0;
      end else begin
         mod_acc_r <= mod_acc_r + cfg_r[msc_pkg::OFF_MOD_INC[6:2]];
         if (adc_valid) ext_r <= adc_sample;
      end
   end

   // pulse waveform admits only pwm, pwm needs a pulse waveform
   msc_pkg::mod_mode_type req_mode, eff_mode;
   assign req_mode = msc_pkg::mod_mode_type'(ctrl.mode);
   assign eff_mode = (ctrl.pulse_wave != (req_mode == msc_pkg::MOD_PWM)) ?
                     msc_pkg::MOD_NONE : req_mode;

   // fsk rate accumulator: msb is a 50 percent square at the programmed rate
   wire [msc_pkg::FSK_ACC_W-1:0] fsk_rate =
      {cfg_r[msc_pkg::OFF_FSK_HI[6:2]][15:0], cfg_r[msc_pkg::OFF_FSK_LO[6:2]]};
   wire fsk_square = fsk_acc_r[msc_pkg::FSK_ACC_W-1];
   assign hop_sel = ctrl.fsk_ext ? trig_lvl : fsk_square;
   always_ff @(posedge clock) begin
      if (rst) fsk_acc_r <= '0;
      else fsk_acc_r <= fsk_acc_r + fsk_rate;
   end

   // modulated carrier values
   wire signed [31:0] fm_off = scale(sample, cfg_r[msc_pkg::OFF_FM_DEV[6:2]]);
   wire signed [31:0] pm_off = scale(sample, {16'h0000, cfg_r[msc_pkg::OFF_PM_DEV[6:2]][15:0]});
   wire signed [31:0] pw_off = scale(sample, cfg_r[msc_pkg::OFF_PW_DEV[6:2]]);
   wire signed [31:0] am_off = scale(sample, cfg_r[msc_pkg::OFF_AM_DEPTH[6:2]]);
   wire [31:0] am_gain = msc_pkg::AM_ONE + am_off;
   wire [msc_pkg::AMP_W-1:0] amp_set = cfg_r[msc_pkg::OFF_AMPLITUDE[6:2]][msc_pkg::AMP_W-1:0];
   wire [msc_pkg::AMP_W+11:0] am_prod = amp_set * am_gain[11:0];
   wire [31:0] pw_nom = cfg_r[msc_pkg::OFF_PW_NOM[6:2]];

   // phase increment source: sweep first, then modulation mode
   logic [31:0] pinc_nxt;
   always_comb begin
      if (ctrl.sweep_en) begin
         pinc_nxt = freq_r;
      end else begin
         case (eff_mode)
            msc_pkg::MOD_FM: pinc_nxt = carrier + fm_off;
            msc_pkg::MOD_FSK: pinc_nxt = hop_sel ? hop : carrier;
            default: pinc_nxt = carrier;
         endcase
      end
   end
   wire [msc_pkg::PHASE_W-1:0] pm_nxt = (eff_mode == msc_pkg::MOD_PM) ?
                                        pm_off[msc_pkg::PHASE_W-1:0] : '0;
   wire [msc_pkg::AMP_W-1:0] amp_nxt = (eff_mode == msc_pkg::MOD_AM) ?
      am_prod[msc_pkg::AM_SHIFT +: msc_pkg::AMP_W] : amp_set;
   wire [31:0] width_nxt = (eff_mode == msc_pkg::MOD_PWM) ? pw_nom + pw_off : pw_nom;

   // carrier accumulator never reloads, so every frequency change is phase-continuous
   always_ff @(posedge clock) begin
      if (rst) begin
         phase_acc_r <= 32'h0000_0000;
         pinc_r <= 32'h0000_0000;
         phase_r <= '0;
         amp_r <= '0;
         width_r <= 32'h0000_0000;
      end else begin
         phase_acc_r <= phase_acc_r + pinc_r;
         pinc_r <= pinc_nxt;
         phase_r <= phase_acc_r[31 -: msc_pkg::PHASE_W] + pm_nxt;
         amp_r <= amp_nxt;
         width_r <= width_nxt;
      end
   end

   // sweep step arithmetic; a zero sweep time still gives one step
   wire [31:0] step_div = cfg_r[msc_pkg::OFF_SW_TIME[6:2]] / msc_pkg::STEP_CYCLES;
   wire [31:0] step_total = (step_div == 32'h0000_0000) ? 32'h0000_0001 : step_div;
   wire [31:0] step_half = step_total >> 1;
   wire [63:0] log_prod = freq_r * cfg_r[msc_pkg::OFF_SW_LOG[6:2]];
   wire [31:0] log_add = log_prod[msc_pkg::LOG_SHIFT +: 32];
   wire [31:0] freq_step = ctrl.sweep_log ? freq_r + log_add :
                           freq_r + cfg_r[msc_pkg::OFF_SW_LIN[6:2]];
   wire sweep_up = sw_stop >= sw_start;
   wire marker_hit = sweep_up ? (freq_step >= marker) : (freq_step <= marker);
   wire step_end = step_tmr_r == 32'(msc_pkg::STEP_CYCLES - 1);
   wire last_step = step_end && (step_cnt_r + 32'h0000_0001 >= step_total);
   wire sync_fall = ctrl.marker_en ? marker_hit :
                    (step_cnt_r + 32'h0000_0001 == step_half);

   // start requests: internal source repeats, external waits for a trigger
   wire ext_trig = trig_rise || key_trig || soft_trig;
   wire can_start = ctrl.sweep_en && (state_r == msc_pkg::SW_IDLE || last_step);
   wire int_start = can_start && !ctrl.sweep_ext;
   wire sweep_start = int_start || (can_start && ctrl.sweep_ext && ext_trig);

   // sweep sequencer
   always_ff @(posedge clock) begin
      if (rst) begin
         state_r <= msc_pkg::SW_IDLE;
         freq_r <= 32'h0000_0000;
         step_cnt_r <= 32'h0000_0000;
         step_tmr_r <= 32'h0000_0000;
         sync_r <= 1'b0;
      end else begin
         case (state_r)
            msc_pkg::SW_IDLE: begin
               step_tmr_r <= 32'h0000_0000;
               if (sweep_start) begin
                  state_r <= msc_pkg::SW_RUN;
                  freq_r <= sw_start;
                  step_cnt_r <= 32'h0000_0000;
                  sync_r <= 1'b1;
               end
            end
            default: begin
               if (!ctrl.sweep_en) begin
                  state_r <= msc_pkg::SW_IDLE;
                  sync_r <= 1'b0;
               end else if (sweep_start) begin
                  freq_r <= sw_start;
                  step_cnt_r <= 32'h0000_0000;
                  step_tmr_r <= 32'h0000_0000;
                  sync_r <= 1'b1;
               end else if (last_step) begin
                  state_r <= msc_pkg::SW_IDLE;
                  sync_r <= 1'b0;
               end else if (step_end) begin
                  step_tmr_r <= 32'h0000_0000;
                  step_cnt_r <= step_cnt_r + 32'h0000_0001;
                  freq_r <= freq_step;
                  if (sync_fall) sync_r <= 1'b0;
               end else begin
                  step_tmr_r <= step_tmr_r + 32'h0000_0001;
               end
            end
         endcase
      end
   end

   // trigger pin as output: one-cycle pulse on each internal trigger
   always_ff @(posedge clock) begin
      if (rst) begin
         trig_out_r <= 1'b0;
         trig_drive_n_r <= 1'b1;
      end else begin
         trig_out_r <= ctrl.trig_out_en && int_start;
         trig_drive_n_r <= !ctrl.trig_out_en;
      end
   end

   assign rdata = rdata_r;
   assign phase_increment_register = pinc_r;
   assign phase_out = phase_r;
   assign amp_out = amp_r;
   assign width_out = width_r;
   assign sync_out = sync_r;
   assign trig_out = trig_out_r;
   assign trig_drive_n = trig_drive_n_r;

   // checks
   chk_sync_start: assert property (@(posedge clock) disable iff (rst)
      sweep_start |=> sync_out) else $error("sync not high after sweep start");
   chk_fsk_hop: assert property (@(posedge clock) disable iff (rst)
      (!ctrl.sweep_en && eff_mode == msc_pkg::MOD_FSK && hop_sel) |=>
      phase_increment_register == $past(hop)) else $error("fsk hop value wrong");
   chk_phase_cont: assert property (@(posedge clock) disable iff (rst)
      ##1 phase_acc_r == $past(phase_acc_r) + $past(pinc_r)) else $error("phase jump");
   chk_pulse_only: assert property (@(posedge clock) disable iff (rst)
      ctrl.pulse_wave |-> eff_mode inside {msc_pkg::MOD_NONE, msc_pkg::MOD_PWM})
      else $error("non-pwm modulation on pulse");
   chk_trig_edge: assert property (@(posedge clock) disable iff (rst)
      trig_rise |-> $past(trig_sync_r) == 1'b0 && $past(trig_in, 3) == 1'b0)
      else $error("trigger edge not from synced level");
   chk_ext_start: assert property (@(posedge clock) disable iff (rst)
      (ctrl.sweep_en && ctrl.sweep_ext && state_r == msc_pkg::SW_IDLE && !ext_trig)
      |=> state_r == msc_pkg::SW_IDLE) else $error("sweep started without trigger");
   chk_marker_keep: assert property (@(posedge clock) disable iff (rst)
      (wr_marker && !marker_ok) |=> marker == $past(marker) && reject_r)
      else $error("bad marker accepted");
   chk_am_ceiling: assert property (@(posedge clock) disable iff (rst)
      (eff_mode == msc_pkg::MOD_AM && cfg_r[msc_pkg::OFF_AM_DEPTH[6:2]] <= msc_pkg::AM_ONE)
      |=> amp_out <= $past(amp_set)) else $error("am above set amplitude");
   chk_trig_drive: assert property (@(posedge clock) disable iff (rst)
      trig_out |-> !trig_drive_n) else $error("trigger pulse while pin not driven");
   chk_fm_pinc: assert property (@(posedge clock) disable iff (rst)
      (!ctrl.sweep_en && eff_mode == msc_pkg::MOD_FM) |=>
      phase_increment_register == $past(carrier + fm_off)) else $error("fm increment wrong");
   chk_pm_offset: assert property (@(posedge clock) disable iff (rst)
      (eff_mode == msc_pkg::MOD_PM) |=>
      phase_out == $past(phase_acc_r[31:16] + pm_off[15:0])) else $error("pm offset wrong");
   chk_pwm_width: assert property (@(posedge clock) disable iff (rst)
      (eff_mode == msc_pkg::MOD_PWM) |=>
      width_out == $past(pw_nom + pw_off)) else $error("pwm width wrong");
   chk_fsk_carrier: assert property (@(posedge clock) disable iff (rst)
      (!ctrl.sweep_en && eff_mode == msc_pkg::MOD_FSK && !hop_sel) |=>
      phase_increment_register == $past(carrier)) else $error("fsk carrier value wrong");
   chk_pin_level: assert property (@(posedge clock) disable iff (rst)
      (ctrl.fsk_ext && !ctrl.trig_out_en) |-> hop_sel == trig_sync_r)
      else $error("fsk select not from pin level");
   // a step boundary that neither ends nor restarts the sweep
   wire mid_step = (state_r == msc_pkg::SW_RUN) && ctrl.sweep_en && step_end && !last_step;
   chk_step_freq: assert property (@(posedge clock) disable iff (rst)
      mid_step |=> freq_r == $past(freq_step))
      else $error("sweep step not applied");
   chk_sync_mid: assert property (@(posedge clock) disable iff (rst)
      (mid_step && !ctrl.marker_en && step_cnt_r + 32'h0000_0001 == step_half) |=> !sync_out)
      else $error("sync not low at midpoint");
   chk_marker_fall: assert property (@(posedge clock) disable iff (rst)
      (mid_step && ctrl.marker_en && marker_hit) |=> !sync_out)
      else $error("sync not low at marker");
   chk_sweep_restart: assert property (@(posedge clock) disable iff (rst)
      (state_r == msc_pkg::SW_RUN && ctrl.sweep_en && !ctrl.sweep_ext && last_step) |=>
      sync_out && freq_r == $past(sw_start)) else $error("internal sweep not repeated");
   chk_one_sweep: assert property (@(posedge clock) disable iff (rst)
      (state_r == msc_pkg::SW_RUN && ctrl.sweep_en && ctrl.sweep_ext && last_step && !ext_trig)
      |=> state_r == msc_pkg::SW_IDLE) else $error("external sweep did not stop");
   chk_trig_pulse: assert property (@(posedge clock) disable iff (rst)
      trig_out |=> !trig_out) else $error("trigger pulse longer than one cycle");
endmodule // modulation_sweep_control

// ==== sim/trig_mod_source.sv ====
`timescale 1ns/1ps
module trig_mod_source (
   // clock
   input wire logic clock,
   // bench side
   input wire logic ext_level,
   input wire logic [11:0] sample,
   // device side
   input wire logic trig_out,
   input wire logic trig_drive_n,
   input wire logic sync_out,
   output logic trig_pin,
   output logic [11:0] adc_sample,
   output logic adc_valid,
   // instrument readings
   output int rises,
   output int pulses,
   output int period,
   output int high_len
);
   int cyc = 0;
   int last = 0;
   logic [1:0] div = 2'h0;
   logic sync_d = 1'b0;
   // pin level: the device owns the wire while its enable is low
   assign trig_pin = trig_drive_n ? ext_level : trig_out;
   // converter gives a word every fourth cycle; bus shows junk between words
   always @(posedge clock) begin
      div <= div + 2'h1;
      adc_valid <= (div == 2'h3);
      adc_sample <= (div == 2'h3) ? sample : ~sample;
   end
   // scope on sync and trigger out: rise count, period, high time
   always @(posedge clock) begin
      cyc <= cyc + 1;
      sync_d <= sync_out;
      if (sync_out && !sync_d) begin
         rises <= rises + 1;
         period <= cyc - last;
         last <= cyc;
      end
      if (!sync_out && sync_d) high_len <= cyc - last;
      if (trig_out) pulses <= pulses + 1;
   end
endmodule // trig_mod_source

// ==== sim/modulation_sweep_control_bench.sv ====
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin errors++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module modulation_sweep_control_bench;
   localparam logic [7:0] EXT = 8'h01, PULSE = 8'h02, FEXT = 8'h04, SWP = 8'h08;
   localparam logic [7:0] SLOG = 8'h10, SEXT = 8'h20, MARK = 8'h40, TOUT = 8'h80;
   localparam logic [31:0] CAR = 32'h0001_0000;
   localparam logic [31:0] HOP = 32'h0002_0000;
   logic clock = 1'b0;
   logic rst = 1'b1;
   msc_pkg::reg_req_type req = '0;
   logic [31:0] rdata, pinc, width_out, d;
   logic [11:0] adc_sample;
   logic [15:0] phase_out, amp_out;
   logic adc_valid, trig_pin, trig_out, trig_drive_n, sync_out, seen, bad;
   logic key_trig = 1'b0;
   logic ext_level = 1'b0;
   logic [11:0] sample = 12'h800;
   int rises, pulses, period, high_len, r0, p0, n, seg0;
   int errors = 0;
   int total_checks = 0;

   modulation_sweep_control dut (
      .clock(clock), .rst(rst), .req(req), .rdata(rdata), .adc_sample(adc_sample),
      .adc_valid(adc_valid), .trig_in(trig_pin), .trig_out(trig_out),
      .trig_drive_n(trig_drive_n), .key_trig(key_trig), .phase_increment_register(pinc),
      .phase_out(phase_out), .amp_out(amp_out), .width_out(width_out), .sync_out(sync_out));
   trig_mod_source far (
      .clock(clock), .ext_level(ext_level), .sample(sample), .trig_out(trig_out),
      .trig_drive_n(trig_drive_n), .sync_out(sync_out), .trig_pin(trig_pin),
      .adc_sample(adc_sample), .adc_valid(adc_valid), .rises(rises), .pulses(pulses),
      .period(period), .high_len(high_len));

   always #10 clock = ~clock;

   // one-cycle strobes; read data taken in the cycle after the strobe
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clock);
      req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clock);
      req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
      @(posedge clock);
      req.rd <= 1'b0;
      #1 d = rdata;
   endtask
   function automatic logic [31:0] cw(input logic [2:0] m, input logic [7:0] f);
      return {21'h0, f, m};
   endfunction
   function automatic logic [31:0] pick(input int w);
      return (w == 0) ? pinc : (w == 1) ? {16'h0000, amp_out} : width_out;
   endfunction
   // bounded wait for an output to settle on a value
   task automatic wait_out(input int w, input logic [31:0] v);
      n = 0;
      while (pick(w) !== v && n < 300) begin
         @(posedge clock);
         #1 n++;
      end
      if (n >= 300) begin
         errors++;
         final_report();
      end
      `CHK(pick(w), v)
   endtask
   task automatic run_len(input logic [31:0] v);
      n = 0;
      while (pinc === v && n < 600) begin
         @(posedge clock);
         #1 n++;
      end
      if (n >= 600) begin
         errors++;
         final_report();
      end
   endtask
   task automatic pulse_pin();
      @(posedge clock);
      ext_level <= 1'b1;
      repeat (3) @(posedge clock);
      ext_level <= 1'b0;
   endtask
   task automatic final_report();
      $display("checks=%0d mismatches=%0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      #1;
      `CHK(trig_drive_n, 1'b1)
      `CHK(sync_out, 1'b0)
      rd(8'h60);
      `CHK(d, 32'h0000_0000)
      wr(msc_pkg::OFF_STATUS, 32'hFFFF_FFFF);
      rd(msc_pkg::OFF_STATUS);
      `CHK(d, 32'h0000_0000)
      wr(msc_pkg::OFF_CARRIER, CAR);
      rd(msc_pkg::OFF_CARRIER);
      `CHK(d, CAR)
      $display("test registers done");
      // external samples at negative full scale
      wr(msc_pkg::OFF_FM_DEV, 32'h0000_1000);
      wr(msc_pkg::OFF_AMPLITUDE, 32'h0000_8000);
      wr(msc_pkg::OFF_AM_DEPTH, 32'h0000_0200);
      wr(msc_pkg::OFF_PW_NOM, 32'h0000_0400);
      wr(msc_pkg::OFF_PW_DEV, 32'h0000_0100);
      wr(msc_pkg::OFF_CTRL, cw(msc_pkg::MOD_FM, EXT));
      wait_out(0, 32'h0000_F000);
      wr(msc_pkg::OFF_CTRL, cw(msc_pkg::MOD_AM, EXT));
      wait_out(1, 32'h0000_2000);
      wr(msc_pkg::OFF_CTRL, cw(msc_pkg::MOD_AM, EXT | PULSE));
      wait_out(1, 32'h0000_8000);
      wr(msc_pkg::OFF_CTRL, cw(msc_pkg::MOD_PWM, EXT | PULSE));
      wait_out(2, 32'h0000_0300);
      wr(msc_pkg::OFF_CTRL, cw(msc_pkg::MOD_PWM, EXT));
      wait_out(2, 32'h0000_0400);
      // phase offset measured against a frozen accumulator
      wr(msc_pkg::OFF_PM_DEV, 32'h0000_4000);
      wr(msc_pkg::OFF_CARRIER, 32'h0000_0000);
      wait_out(0, 32'h0000_0000);
      repeat (3) @(posedge clock);
      #1 d = {16'h0000, phase_out};
      wr(msc_pkg::OFF_CTRL, cw(msc_pkg::MOD_PM, EXT));
      repeat (3) @(posedge clock);
      #1;
      `CHK(phase_out, d[15:0] - 16'h4000)
      wr(msc_pkg::OFF_CARRIER, CAR);
      // internal source: pinc must move, but never past the deviation
      wr(msc_pkg::OFF_MOD_INC, 32'h0100_0000);
      wr(msc_pkg::OFF_CTRL, cw(msc_pkg::MOD_FM, 8'h00));
      seen = 1'b0;
      bad = 1'b0;
      repeat (600) begin
         @(posedge clock);
         #1;
         if (pinc !== CAR) seen = 1'b1;
         if (pinc > CAR + 32'h0000_1000 || pinc < CAR - 32'h0000_1000) bad = 1'b1;
      end
      `CHK(seen, 1'b1)
      `CHK(bad, 1'b0)
      $display("test modulation done");
      // frequency keying from the pin, then from the rate generator
      wr(msc_pkg::OFF_HOP, HOP);
      wr(msc_pkg::OFF_CTRL, cw(msc_pkg::MOD_FSK, FEXT));
      @(posedge clock);
      ext_level <= 1'b1;
      wait_out(0, HOP);
      rd(msc_pkg::OFF_STATUS);
      `CHK(d[3], 1'b1)
      @(posedge clock);
      ext_level <= 1'b0;
      wait_out(0, CAR);
      wr(msc_pkg::OFF_FSK_LO, 32'h0000_0000);
      wr(msc_pkg::OFF_FSK_HI, 32'h0000_0100);
      wr(msc_pkg::OFF_CTRL, cw(msc_pkg::MOD_FSK, 8'h00));
      wait_out(0, HOP);
      wait_out(0, CAR);
      run_len(CAR);
      seg0 = n;
      run_len(HOP);
      `CHK(n < 600, 1'b1)
      `CHK(seg0, n)
      $display("test keying done");
      // linear sweep of four 16-cycle steps, trigger pin as output
      wr(msc_pkg::OFF_SW_START, 32'h0000_03E8);
      wr(msc_pkg::OFF_SW_STOP, 32'h0000_0428);
      wr(msc_pkg::OFF_SW_LIN, 32'h0000_0010);
      wr(msc_pkg::OFF_SW_TIME, 32'h0000_0040);
      wr(msc_pkg::OFF_CTRL, cw(msc_pkg::MOD_NONE, SWP | TOUT));
      wait_out(0, 32'h0000_03F8);
      r0 = rises;
      p0 = pulses;
      repeat (192) @(posedge clock);
      #1;
      `CHK(rises - r0, 3)
      `CHK(pulses - p0, 3)
      `CHK(period, 64)
      `CHK(high_len, 32)
      `CHK(trig_drive_n, 1'b0)
      wr(msc_pkg::OFF_MARKER, 32'h0000_03F8);
      wr(msc_pkg::OFF_CTRL, cw(msc_pkg::MOD_NONE, SWP | MARK));
      repeat (192) @(posedge clock);
      #1;
      `CHK(high_len, 16)
      // logarithmic sweep, ratio one sixteenth per step
      wr(msc_pkg::OFF_SW_START, CAR);
      wr(msc_pkg::OFF_SW_STOP, HOP);
      wr(msc_pkg::OFF_SW_LOG, 32'h0010_0000);
      wr(msc_pkg::OFF_CTRL, cw(msc_pkg::MOD_NONE, SWP | SLOG));
      wait_out(0, 32'h0001_1000);
      // marker outside the sweep range is refused and flagged
      wr(msc_pkg::OFF_MARKER, 32'h0000_0800);
      rd(msc_pkg::OFF_STATUS);
      `CHK(d[2], 1'b1)
      wr(msc_pkg::OFF_CMD, 32'h0000_0002);
      wr(msc_pkg::OFF_MARKER, 32'h0001_8000);
      rd(msc_pkg::OFF_STATUS);
      `CHK(d[2], 1'b0)
      rd(msc_pkg::OFF_MARKER);
      `CHK(d, 32'h0001_8000)
      $display("test sweep done");
      // triggered sweeps: pin, pin again mid-sweep, key, command
      wr(msc_pkg::OFF_CTRL, cw(msc_pkg::MOD_NONE, SWP | SEXT));
      repeat (100) @(posedge clock);
      r0 = rises;
      pulse_pin();
      repeat (20) @(posedge clock);
      pulse_pin();
      repeat (100) @(posedge clock);
      `CHK(rises - r0, 1)
      @(posedge clock);
      key_trig <= 1'b1;
      @(posedge clock);
      key_trig <= 1'b0;
      repeat (100) @(posedge clock);
      `CHK(rises - r0, 2)
      wr(msc_pkg::OFF_CMD, 32'h0000_0001);
      repeat (100) @(posedge clock);
      `CHK(rises - r0, 3)
      $display("test triggers done");
      final_report();
   end
endmodule // modulation_sweep_control_bench
